// ===== logic/flid_defs.vh
// constants for the flash identification host controller
`ifndef FLID_DEFS_VH
`define FLID_DEFS_VH
`define FLID_REG_CTRL 12'h000
`define FLID_REG_ADDR 12'h004
`define FLID_REG_STAT 12'h008
`define FLID_REG_DATA 12'h00C
`define FLID_CTRL_START 0
`define FLID_CTRL_IDV 1
`define FLID_CTRL_KIND_LO 2
`define FLID_CTRL_KIND_HI 4
`define FLID_KIND_MAKER 3'h0
`define FLID_KIND_DEV1 3'h1
`define FLID_KIND_DEV2 3'h2
`define FLID_KIND_DEV3 3'h3
`define FLID_KIND_PROT 3'h4
`define FLID_KIND_LOCK 3'h5
`define FLID_KIND_ARRAY 3'h6
`define FLID_STAT_BUSY 0
`define FLID_STAT_DONE 1
`define FLID_STAT_PROT 2
`define FLID_STAT_LOCK 3
`define FLID_STAT_WPLOW 4
`define FLID_ADDR_W 22
`define FLID_SECT_LO 15
`define FLID_IDPIN_BIT 9
`define FLID_A6_BIT 6
`define FLID_DEV2_LOW 8'h0E
`define FLID_DEV3_LOW 8'h0F
`define FLID_PROT_YES 8'h01
`define FLID_LOCK_BIT 7
`define FLID_WPLOW_BIT 4
`define FLID_ACCESS_NS 70
`define FLID_SETTLE_NS 500
`define FLID_CLK_NS 4
`endif

// ===== logic/flid_tick.v
// down-counter giving a one-cycle pulse after a programmed wait
`timescale 1ns/1ps
module flid_tick #(
  parameter W = 8
) (
  clk,
  reset,
  load,
  count,
  expired
);
  input wire clk;
  input wire reset;
  input wire load;
  input wire [W-1:0] count;
  output reg expired;
  reg [W-1:0] cnt_ff;
  reg run_ff;
  always @(posedge clk) begin
    if (reset) begin
      cnt_ff <= {W{1'b0}};
      run_ff <= 1'b0;
      expired <= 1'b0;
    end else begin
      expired <= 1'b0;
      if (load) begin
        cnt_ff <= count;
        run_ff <= 1'b1;
      end else if (run_ff) begin
        if (cnt_ff == {W{1'b0}}) begin
          run_ff <= 1'b0;
          expired <= 1'b1;
        end else begin
          cnt_ff <= cnt_ff - {{(W-1){1'b0}}, 1'b1};
        end
      end
    end
  end
endmodule // flid_tick

// ===== logic/flid_host.v
// host controller reading identification codes from a parallel flash
// Behaviour
// RL1: seven top word-address bits pick one of 128 sectors of 32 Kwords.
// RL2: in identification mode the device returns codes on the low data byte.
// RL3: host holds id pin at id voltage, chip and output enable low, write high.
// RL4: address bit six low; bits one and zero choose the code kind.
// RL5: device code takes three reads; later two need low byte 0Eh then 0Fh.
// RL6: protection query places sector on top bits; 01h protected, 00h not.
// RL7: lock indicator in bit seven; bit four low means lowest sector guarded.
// RL8: device ignores don't-care address bits for identification reads.
// RL9: device can also enter identification by a command, without high voltage; this host issues no commands and keeps writeEnableN high.
// RL10: dropping the id voltage returns the next read to array data.
//
// Design decisions made here: the register addresses and register access over APB.
`timescale 1ns/1ps
`include "flid_defs.vh"
module flid_host #(
  parameter ACCESS_CYC = (`FLID_ACCESS_NS + `FLID_CLK_NS - 1) / `FLID_CLK_NS,
  parameter SETTLE_CYC = (`FLID_SETTLE_NS + `FLID_CLK_NS - 1) / `FLID_CLK_NS
) (
  clk,
  reset,
  psel,
  penable,
  pwrite,
  paddr,
  pwdata,
  prdata,
  pready,
  pslverr,
  flashAddr,
  idVoltageEnable,
  chipEnableN,
  outputEnableN,
  writeEnableN,
  flashDataIn
);
  input wire clk;
  input wire reset;
  input wire psel;
  input wire penable;
  input wire pwrite;
  input wire [11:0] paddr;
  input wire [31:0] pwdata;
  output reg [31:0] prdata;
  output reg pready;
  output reg pslverr;
  output reg [`FLID_ADDR_W-1:0] flashAddr;
  output reg idVoltageEnable;
  output reg chipEnableN;
  output reg outputEnableN;
  output reg writeEnableN;
  input wire [15:0] flashDataIn;

  localparam S_IDLE = 4'b0001;
  localparam S_SETUP = 4'b0010;
  localparam S_READ = 4'b0100;
  localparam S_DONE = 4'b1000;

  reg [3:0] state_ff;
  reg [15:0] dataMeta_ff;
  reg [15:0] dataSync_ff;
  reg idvReq_ff;
  reg [2:0] kind_ff;
  reg [6:0] sector_ff;
  reg [21:0] arrAddr_ff;
  reg [15:0] result_ff;
  reg done_ff;
  reg timerLoad;
  reg [7:0] timerCount;
  wire timerDone;
  wire access = psel & penable;
  wire wrCtrl = access & pwrite & (paddr == `FLID_REG_CTRL);
  wire startReq = wrCtrl & pwdata[`FLID_CTRL_START] & (state_ff == S_IDLE);

  flid_tick #(.W(8)) uTimer (
    .clk(clk),
    .reset(reset),
    .load(timerLoad),
    .count(timerCount),
    .expired(timerDone)
  );

  // data pins are asynchronous to clk
  always @(posedge clk) begin
    dataMeta_ff <= flashDataIn;
    dataSync_ff <= dataMeta_ff;
  end

  // address presented for the chosen code; unused bits driven low
  reg [21:0] nxt_addr;
  always @* begin
    nxt_addr = 22'h000000;
    if (kind_ff == `FLID_KIND_ARRAY) begin
      nxt_addr = arrAddr_ff;
    end else begin
      nxt_addr[`FLID_A6_BIT] = 1'b0; // RL4
      case (kind_ff)
        `FLID_KIND_MAKER: nxt_addr[1:0] = 2'b00; // RL4
        `FLID_KIND_DEV1: nxt_addr[1:0] = 2'b01; // RL5
        `FLID_KIND_DEV2: nxt_addr[7:0] = `FLID_DEV2_LOW; // RL5
        `FLID_KIND_DEV3: nxt_addr[7:0] = `FLID_DEV3_LOW; // RL5
        `FLID_KIND_PROT: begin
          nxt_addr[1:0] = 2'b10;
          nxt_addr[21:`FLID_SECT_LO] = sector_ff; // RL6 RL1
        end
        default: nxt_addr[1:0] = 2'b11; // RL7
      endcase
    end
  end

  always @* begin
    timerLoad = 1'b0;
    timerCount = 8'h00;
    if (startReq) begin
      timerLoad = 1'b1;
      timerCount = SETTLE_CYC[7:0];
    end else if (state_ff == S_SETUP && timerDone) begin
      timerLoad = 1'b1;
      timerCount = ACCESS_CYC[7:0];
    end
  end

  always @(posedge clk) begin
    if (reset) begin
      state_ff <= S_IDLE;
      idvReq_ff <= 1'b0;
      kind_ff <= `FLID_KIND_MAKER;
      sector_ff <= 7'h00;
      arrAddr_ff <= 22'h000000;
      result_ff <= 16'h0000;
      done_ff <= 1'b0;
      flashAddr <= 22'h000000;
      idVoltageEnable <= 1'b0;
      chipEnableN <= 1'b1;
      outputEnableN <= 1'b1;
      writeEnableN <= 1'b1;
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel & ~penable;
      pslverr <= 1'b0;
      if (psel & ~penable & ~pwrite) begin
        if (paddr == `FLID_REG_CTRL) begin
          prdata <= {27'h0, kind_ff, idvReq_ff, 1'b0};
        end else if (paddr == `FLID_REG_ADDR) begin
          prdata <= {10'h000, arrAddr_ff};
        end else if (paddr == `FLID_REG_STAT) begin
          prdata <= {27'h0, ~result_ff[`FLID_WPLOW_BIT], result_ff[`FLID_LOCK_BIT],
            result_ff[0], done_ff, (state_ff != S_IDLE)};
        end else if (paddr == `FLID_REG_DATA) begin
          prdata <= {16'h0000, result_ff};
        end else begin
          prdata <= 32'h00000000;
        end
      end
      if (psel & ~penable & paddr != `FLID_REG_CTRL & paddr != `FLID_REG_ADDR
          & paddr != `FLID_REG_STAT & paddr != `FLID_REG_DATA) begin
        pslverr <= 1'b1;
      end
      if (access & pwrite & (paddr == `FLID_REG_ADDR) & (state_ff == S_IDLE)) begin
        arrAddr_ff <= pwdata[21:0];
        sector_ff <= pwdata[21:`FLID_SECT_LO]; // RL1
      end
      case (state_ff)
        S_IDLE: begin
          if (startReq) begin
            kind_ff <= pwdata[`FLID_CTRL_KIND_HI:`FLID_CTRL_KIND_LO];
            idvReq_ff <= pwdata[`FLID_CTRL_IDV];
            // array reads drop the id voltage first
            idVoltageEnable <= pwdata[`FLID_CTRL_IDV]
              & (pwdata[`FLID_CTRL_KIND_HI:`FLID_CTRL_KIND_LO] != `FLID_KIND_ARRAY); // RL3 RL10
            writeEnableN <= 1'b1; // RL3
            done_ff <= 1'b0;
            state_ff <= S_SETUP;
          end
        end
        S_SETUP: begin
          flashAddr <= nxt_addr;
          if (timerDone) begin
            chipEnableN <= 1'b0; // RL3
            outputEnableN <= 1'b0; // RL3
            state_ff <= S_READ;
          end
        end
        S_READ: begin
          if (timerDone) begin
            // only the low byte is meaningful for codes
            result_ff <= (kind_ff == `FLID_KIND_ARRAY) ? dataSync_ff
              : {8'h00, dataSync_ff[7:0]}; // RL2 RL8
            chipEnableN <= 1'b1;
            outputEnableN <= 1'b1;
            state_ff <= S_DONE;
          end
        end
        default: begin
          done_ff <= 1'b1;
          state_ff <= S_IDLE;
        end
      endcase
    end
  end
endmodule // flid_host

// ===== testbench/flid_host_sva.sv
// assertions on the flash-side pins of the host controller
`timescale 1ns/1ps
module flid_host_sva (
  clk,
  reset,
  flashAddr,
  idVoltageEnable,
  chipEnableN,
  outputEnableN,
  writeEnableN
);
  input wire clk;
  input wire reset;
  input wire [21:0] flashAddr;
  input wire idVoltageEnable;
  input wire chipEnableN;
  input wire outputEnableN;
  input wire writeEnableN;
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  sequence readLow; !outputEnableN && !chipEnableN; endsequence
  // three idle cycles fit the bench's settle count of 2
  sequence settle; outputEnableN [*3]; endsequence
  AST_STROBES: assert property (!outputEnableN |-> !chipEnableN && writeEnableN) else $error("strobe mix");
  AST_A6LOW: assert property (idVoltageEnable && !outputEnableN |-> !flashAddr[6]) else $error("a6 high");
  AST_HOLD: assert property (readLow ##1 readLow |-> $stable(flashAddr) && $stable(idVoltageEnable))
    else $error("moved in read");
  AST_SETTLE: assert property ($rose(idVoltageEnable) |-> settle) else $error("read too soon");
  AST_DEVLOW: assert property (idVoltageEnable && !outputEnableN && flashAddr[3:2] != 2'h0
    |-> flashAddr[7:0] inside {8'h0E, 8'h0F}) else $error("bad device step");
endmodule // flid_host_sva
bind flid_host flid_host_sva chk(.clk(clk), .reset(reset), .flashAddr(flashAddr), .idVoltageEnable(idVoltageEnable),
  .chipEnableN(chipEnableN), .outputEnableN(outputEnableN), .writeEnableN(writeEnableN));

// ===== testbench/flid_flash_model.sv
// behavioural flash giving id codes and array words
`timescale 1ns/1ps
module flid_flash_model #(
  parameter [15:0] MAKER = 16'h00C3, // arbitrary value
  parameter [15:0] DEV1 = 16'h1234, // arbitrary value
  parameter [15:0] DEV2 = 16'h1256, // arbitrary value
  parameter [15:0] DEV3 = 16'h1278, // arbitrary value
  parameter [31:0] PROT = 32'h80000001
) (
  clk,
  addr,
  idv,
  ceN,
  oeN,
  weN,
  q
);
  input wire clk;
  input wire [21:0] addr;
  input wire idv;
  input wire ceN;
  input wire oeN;
  input wire weN;
  output logic [15:0] q;
  logic [15:0] last = 16'h0000;
  logic [15:0] code;
  wire [6:0] sector = addr[21:15];
  always @* begin
    case (addr[1:0])
      2'h0: code = MAKER;
      2'h1: code = DEV1;
      2'h2: code = {15'h0000, PROT[sector[6:2]]};
      default: code = 16'h0098;
    endcase
    // device cycles two and three are picked by the whole low byte
    if (addr[7:0] == 8'h0E) code = DEV2;
    else if (addr[7:0] == 8'h0F) code = DEV3;
    if (!idv) code = addr[15:0] ^ 16'h5A5A;
    else if (addr[6]) code = ~code;
    // released bus shows a changing pattern, never a stale value
    q = (!ceN && !oeN && weN) ? code : ~last;
  end
  always @(posedge clk) last <= q;
endmodule // flid_flash_model

// ===== testbench/flid_host_tb.sv
// self-checking bench for the flash identification host controller
`timescale 1ns/1ps
`include "flid_defs.vh"
module flid_host_tb;
  logic clk = 0, reset = 1, psel = 0, penable = 0, pwrite = 0, pready, pslverr, se, idv, ceN, oeN, weN;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd, st;
  logic [21:0] fa;
  logic [15:0] fq;
  int errTotal = 0, checked = 0, cyc = 0;
  always #2 clk = ~clk;
  flid_host #(.ACCESS_CYC(2), .SETTLE_CYC(2)) dut(.clk(clk), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .flashAddr(fa), .idVoltageEnable(idv), .chipEnableN(ceN), .outputEnableN(oeN), .writeEnableN(weN),
    .flashDataIn(fq));
  flid_flash_model mem(.clk(clk), .addr(fa), .idv(idv), .ceN(ceN), .oeN(oeN), .weN(weN), .q(fq));
  task results;
    $display("errors %0d checks %0d", errTotal, checked);
    if (errTotal == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 6000) begin
      errTotal++;
      results;
    end
  end
  task chk(input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      errTotal++;
      $display("unexpected %0t got %h want %h", $time, s, e);
    end
  endtask
  // idle edge first so no signal is assigned twice in one step
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'h1;
    do @(posedge clk); while (pready !== 1'h1);
    rd = prdata;
    se = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task ident(input logic [2:0] k, input logic idOn, input logic [21:0] a);
    apb(1'h1, `FLID_REG_ADDR, {10'h000, a});
    apb(1'h1, `FLID_REG_CTRL, {27'h0, k, idOn, 1'h1});
    do apb(1'h0, `FLID_REG_STAT, 32'h0); while (rd[0] !== 1'h1);
    do apb(1'h0, `FLID_REG_STAT, 32'h0); while (rd[1] !== 1'h1);
    st = rd;
    apb(1'h0, `FLID_REG_DATA, 32'h0);
  endtask
  task sc_codes;
    logic [15:0] exp[4];
    exp = '{mem.MAKER, mem.DEV1, mem.DEV2, mem.DEV3};
    for (int i = 0; i < 4; i++) begin
      // all-ones address: don't-care bits and a6 must be cleaned by the host
      ident(i[2:0], 1'h1, 22'h3FFFFF);
      chk(rd & 32'hFF, exp[i][7:0]);
    end
  endtask
  task sc_protect;
    logic [21:0] pa[3];
    logic pe[3];
    pa = '{22'h000000, 22'h3F8000, 22'h020000};
    pe = '{1'h1, 1'h1, 1'h0};
    for (int i = 0; i < 3; i++) begin
      ident(`FLID_KIND_PROT, 1'h1, pa[i]);
      chk(rd & 32'hFF, pe[i]);
      chk(st[2], pe[i]);
    end
  endtask
  task sc_lock_array;
    ident(`FLID_KIND_LOCK, 1'h1, 22'h000000);
    chk(rd & 32'hFF, 32'h98);
    chk(st[4:3], 2'h1);
    ident(`FLID_KIND_ARRAY, 1'h0, 22'h012345);
    chk(rd & 32'hFFFF, 32'h791F);
  endtask
  task sc_unmapped;
    apb(1'h0, 12'h010, 32'h0);
    chk({31'h0, se}, 32'h1);
    chk(rd, 32'h0);
  endtask
  initial begin
    repeat (12) @(posedge clk);
    reset <= 1'h0;
    sc_codes;
    sc_protect;
    sc_lock_array;
    sc_unmapped;
    results;
  end
endmodule // flid_host_tb
